/* File: adcac_map.vh */
// register map, field positions, reset values and timing for adcac_top
`ifndef ADCAC_MAP_VH
`define ADCAC_MAP_VH

// ---------------------------------------------------------------
// system registers (byte addresses)
// ---------------------------------------------------------------
`define ADCAC_SYS_CTRL 12'h000
`define ADCAC_ALARM 12'h004
`define ADCAC_GPIO_DIR 12'h008
`define ADCAC_GPIO_OUT 12'h00C
`define ADCAC_GPIO_IN 12'h010
`define ADCAC_SEQ_MASK 12'h014
`define ADCAC_STATUS 12'h018
// ---------------------------------------------------------------
// per-channel and coefficient windows
// ---------------------------------------------------------------
`define ADCAC_CH_BASE 4'h1
`define ADCAC_COEF_BASE 4'h2
`define ADCAC_CH_RATE 2'h0
`define ADCAC_CH_UPPER 2'h1
`define ADCAC_CH_LOWER 2'h2
`define ADCAC_CH_CTL 2'h3
// ---------------------------------------------------------------
// fields
// ---------------------------------------------------------------
`define ADCAC_SYS_POLICY 0
`define ADCAC_SYS_PREPEND 1
`define ADCAC_SYS_RUN 2
`define ADCAC_RATE_PAIR_HI 15
`define ADCAC_RATE_PAIR_LO 12
`define ADCAC_RATE_PER_HI 11
`define ADCAC_CTL_DIFF 0
`define ADCAC_CTL_DLY_HI 31
`define ADCAC_CTL_DLY_LO 16
`define ADCAC_AL_OVER 0
`define ADCAC_AL_UNDER 8
`define ADCAC_AL_SAT 16
// ---------------------------------------------------------------
// reset values and constants
// ---------------------------------------------------------------
`define ADCAC_RATE_RST 16'h3010
`define ADCAC_UPPER_RST 24'hFF_FFFF
`define ADCAC_LOWER_RST 24'h00_0000
`define ADCAC_GAIN_UNITY 24'h40_0000
`define ADCAC_GAIN_FRAC 22
`define ADCAC_CODE_MAX_U 24'hFF_FFFF
`define ADCAC_CODE_MAX_S 24'h7F_FFFF
`define ADCAC_CODE_MIN_S 24'h80_0000
`define ADCAC_PER_SHIFT 4
`define ADCAC_COEF_LAST 5'h1F

`endif

/* File: adcac_top.v */
// alarm, calibration, sequencing and gpio back end behind an apb slave
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ns
`include "adcac_map.vh"
// What this block does
// - saturation alarm when result reaches maximum code
// - saturation alarm only in differential mode
// - over/under flags from per-channel limit registers
// - sixteen gain plus sixteen offset coefficient registers
// - reset copies existing factory coefficients from nvm
// - coefficients stay writable after the load
// - correct each result with selected pair
// - factory pairs 0-7 match gains 0.2-16
// - pair-select field in channel rate register
// - any channel may use any pair
// - channel slot is delay plus conversion period
// - ten general-purpose pins
// - each pin individually input or output
// - alarm clears on read or write-one
// - optional status byte ahead of data
module adcac_top (
  input wire core_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rawValid,
  input wire [2:0] rawChan,
  input wire [23:0] rawCode,
  output reg convStart,
  output reg [2:0] convChan,
  output reg resValid,
  output reg [2:0] resChan,
  output reg [31:0] resWord,
  output reg nvmRdReq,
  output reg [4:0] nvmAddr,
  input wire nvmAck,
  input wire nvmHasData,
  input wire [23:0] nvmData,
  output reg loadBusy,
  input wire overTempPin,
  input wire overVoltPin,
  input wire crcErrPin,
  input wire [9:0] gpioIn,
  output reg [9:0] gpioOut,
  output reg [9:0] gpioOe_n
);
  localparam NCH = 8;
  localparam NPIN = 10;
  localparam S_IDLE = 3'b001;
  localparam S_DELAY = 3'b010;
  localparam S_CONV = 3'b100;

  integer i;

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  reg [2:0] sysCtrl_reg;
  reg [23:0] alarm_reg;
  reg [23:0] alarm_next;
  reg [7:0] seqMask_reg;
  reg [15:0] rate_reg [0:NCH-1];
  reg [23:0] upper_reg [0:NCH-1];
  reg [23:0] lower_reg [0:NCH-1];
  reg [31:0] chCtl_reg [0:NCH-1];
  reg [23:0] gainMem [0:15];
  reg [23:0] offMem [0:15];
  reg [9:0] gpioSyncA;
  reg [9:0] gpioSyncB;
  reg [2:0] pinSyncA;
  reg [2:0] pinSyncB;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire setupPh = psel & ~penable;
  wire accessDone = psel & penable & pready;
  wire wrDone = accessDone & pwrite;
  wire [2:0] chSel = paddr[6:4];
  wire [3:0] coefSel = paddr[5:2];
  wire inSys = (paddr[11:8] == 4'h0) & (paddr[7:5] == 3'b000);
  wire inCh = (paddr[11:8] == `ADCAC_CH_BASE) & ~paddr[7];
  wire inCoef = (paddr[11:8] == `ADCAC_COEF_BASE) & ~paddr[7];
  wire sysOk = inSys & (paddr[4:2] <= 3'd6);
  wire addrOk = (paddr[1:0] == 2'b00) & (sysOk | inCh | inCoef);
  reg [31:0] rdData;

  always @* begin
    rdData = 32'h0000_0000;
    if (inSys) begin
      case (paddr)
        `ADCAC_SYS_CTRL: rdData = {29'h0000_0000, sysCtrl_reg};
        `ADCAC_ALARM: rdData = {8'h00, alarm_reg};
        `ADCAC_GPIO_DIR: rdData = {22'h00_0000, ~gpioOe_n};
        `ADCAC_GPIO_OUT: rdData = {22'h00_0000, gpioOut};
        `ADCAC_GPIO_IN: rdData = {22'h00_0000, gpioSyncB};
        `ADCAC_SEQ_MASK: rdData = {24'h00_0000, seqMask_reg};
        `ADCAC_STATUS: rdData = {27'h000_0000, convChan, 1'b0, loadBusy};
        default: rdData = 32'h0000_0000;
      endcase
    end else if (inCh) begin
      case (paddr[3:2])
        `ADCAC_CH_RATE: rdData = {16'h0000, rate_reg[chSel]};
        `ADCAC_CH_UPPER: rdData = {8'h00, upper_reg[chSel]};
        `ADCAC_CH_LOWER: rdData = {8'h00, lower_reg[chSel]};
        default: rdData = chCtl_reg[chSel];
      endcase
    end else if (inCoef) begin
      rdData = {8'h00, paddr[6] ? offMem[coefSel] : gainMem[coefSel]};
    end
  end

  // zero-wait slave: pready rises in the first access cycle
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setupPh;
      pslverr <= setupPh & ~addrOk;
      prdata <= setupPh ? rdData : 32'h0000_0000;
    end
  end

  wire sysWr = wrDone & addrOk & inSys;
  wire chWr = wrDone & addrOk & inCh;
  wire coefWr = wrDone & addrOk & inCoef;

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sysCtrl_reg <= 3'b000;
      seqMask_reg <= 8'h00;
      gpioOut <= 10'h000;
      gpioOe_n <= 10'h3FF;
      for (i = 0; i < NCH; i = i + 1) begin
        rate_reg[i] <= `ADCAC_RATE_RST;
        upper_reg[i] <= `ADCAC_UPPER_RST;
        lower_reg[i] <= `ADCAC_LOWER_RST;
        chCtl_reg[i] <= 32'h0000_0000;
      end
    end else begin
      if (sysWr) begin
        case (paddr)
          `ADCAC_SYS_CTRL: sysCtrl_reg <= pwdata[2:0];
          `ADCAC_GPIO_DIR: gpioOe_n <= ~pwdata[9:0];
          `ADCAC_GPIO_OUT: gpioOut <= pwdata[9:0];
          `ADCAC_SEQ_MASK: seqMask_reg <= pwdata[7:0];
          default: ;
        endcase
      end
      if (chWr) begin
        case (paddr[3:2])
          `ADCAC_CH_RATE: rate_reg[chSel] <= pwdata[15:0];
          `ADCAC_CH_UPPER: upper_reg[chSel] <= pwdata[23:0];
          `ADCAC_CH_LOWER: lower_reg[chSel] <= pwdata[23:0];
          default: chCtl_reg[chSel] <= pwdata;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // coefficient load from nvm
  // ---------------------------------------------------------------
  // one entry per acknowledged read: 0-15 gains, 16-31 offsets
  wire ldWr = nvmRdReq & nvmAck;
  wire [23:0] ldDefault = nvmAddr[4] ? 24'h00_0000 : `ADCAC_GAIN_UNITY;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      nvmRdReq <= 1'b1;
      nvmAddr <= 5'h00;
      loadBusy <= 1'b1;
    end else if (ldWr) begin
      nvmAddr <= nvmAddr + 5'h01;
      if (nvmAddr == `ADCAC_COEF_LAST) begin
        nvmRdReq <= 1'b0;
        loadBusy <= 1'b0;
      end
    end
  end

  // no reset on the arrays: the loader fills every entry after reset
  always @(posedge core_clk) begin
    if (ldWr) begin
      // factory pairs 0-7 hold the per-gain calibration
      if (nvmAddr[4])
        offMem[nvmAddr[3:0]] <= nvmHasData ? nvmData : ldDefault;
      else
        gainMem[nvmAddr[3:0]] <= nvmHasData ? nvmData : ldDefault;
    end else if (coefWr) begin
      if (paddr[6])
        offMem[coefSel] <= pwdata[23:0];
      else
        gainMem[coefSel] <= pwdata[23:0];
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : gPin
      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          gpioSyncA[g] <= 1'b0;
          gpioSyncB[g] <= 1'b0;
        end else begin
          gpioSyncA[g] <= gpioIn[g];
          gpioSyncB[g] <= gpioSyncA[g];
        end
      end
    end
  endgenerate

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pinSyncA <= 3'b000;
      pinSyncB <= 3'b000;
    end else begin
      pinSyncA <= {overTempPin, overVoltPin, crcErrPin};
      pinSyncB <= pinSyncA;
    end
  end

  // ---------------------------------------------------------------
  // correction pipeline
  // ---------------------------------------------------------------
  reg s1Valid;
  reg [2:0] s1Chan;
  reg s1Diff;
  reg signed [25:0] s1Sum;
  reg [23:0] s1Gain;
  wire [3:0] pairSel = rate_reg[rawChan][15:12];
  wire rawDiff = chCtl_reg[rawChan][`ADCAC_CTL_DIFF];
  wire [23:0] rawOff = offMem[pairSel];
  // differential codes are offset binary, single-ended two's complement
  wire signed [25:0] rawExt = rawDiff ? {2'b00, rawCode} :
    {{2{rawCode[23]}}, rawCode};

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1Valid <= 1'b0;
      s1Chan <= 3'd0;
      s1Diff <= 1'b0;
      s1Sum <= 26'sd0;
      s1Gain <= 24'h00_0000;
    end else begin
      s1Valid <= rawValid;
      if (rawValid) begin
        s1Chan <= rawChan;
        s1Diff <= rawDiff;
        s1Sum <= rawExt + {{2{rawOff[23]}}, rawOff};
        s1Gain <= gainMem[pairSel];
      end
    end
  end

  wire signed [50:0] prod = s1Sum * $signed({1'b0, s1Gain});
  wire signed [28:0] scaled = prod[50:22];
  reg [23:0] corr;

  always @* begin
    corr = scaled[23:0];
    if (s1Diff) begin
      if (scaled < 29'sd0)
        corr = 24'h00_0000;
      else if (scaled > $signed({5'b00000, `ADCAC_CODE_MAX_U}))
        corr = `ADCAC_CODE_MAX_U;
    end else begin
      if (scaled > $signed({5'b00000, `ADCAC_CODE_MAX_S}))
        corr = `ADCAC_CODE_MAX_S;
      else if (scaled < $signed({5'b11111, `ADCAC_CODE_MIN_S}))
        corr = `ADCAC_CODE_MIN_S;
    end
  end

  wire [23:0] upLim = upper_reg[s1Chan];
  wire [23:0] loLim = lower_reg[s1Chan];
  wire overLoad = s1Diff & (corr == `ADCAC_CODE_MAX_U);
  wire underLoad = s1Diff & (corr == 24'h00_0000);
  wire overLim = s1Diff ? (corr > upLim) :
    ($signed(corr) > $signed(upLim));
  wire underLim = s1Diff ? (corr < loLim) :
    ($signed(corr) < $signed(loLim));

  // ---------------------------------------------------------------
  // alarm register
  // ---------------------------------------------------------------
  wire [7:0] chHot = s1Valid ? (8'h01 << s1Chan) : 8'h00;
  wire [23:0] alarmSet = {overLoad ? chHot : 8'h00,
    underLim ? chHot : 8'h00, overLim ? chHot : 8'h00};
  wire alarmAcc = accessDone & addrOk & inSys & (paddr == `ADCAC_ALARM);
  reg [23:0] alarmClr;

  always @* begin
    alarmClr = 24'h00_0000;
    if (alarmAcc) begin
      if (sysCtrl_reg[`ADCAC_SYS_POLICY])
        alarmClr = pwrite ? pwdata[23:0] : 24'h00_0000;
      else if (!pwrite)
        alarmClr = prdata[23:0];
    end
    // set wins over a clear in the same cycle
    alarm_next = (alarm_reg & ~alarmClr) | alarmSet;
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst)
      alarm_reg <= 24'h00_0000;
    else
      alarm_reg <= alarm_next;
  end

  // ---------------------------------------------------------------
  // result output
  // ---------------------------------------------------------------
  wire [7:0] statusByte = {overLoad, underLoad, overLim, underLim,
    pinSyncB[2], |alarm_reg, pinSyncB[1], pinSyncB[0]};

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      resValid <= 1'b0;
      resChan <= 3'd0;
      resWord <= 32'h0000_0000;
    end else begin
      resValid <= s1Valid;
      if (s1Valid) begin
        resChan <= s1Chan;
        resWord <= {sysCtrl_reg[`ADCAC_SYS_PREPEND] ? statusByte : 8'h00,
          corr};
      end
    end
  end

  // ---------------------------------------------------------------
  // channel sequencer
  // ---------------------------------------------------------------
  reg [2:0] seqState;
  reg [15:0] seqCnt;
  wire [2:0] nextChan = convChan + 3'd1;
  wire [15:0] convCycles = {rate_reg[convChan][11:0], 4'h0};
  wire seqRun = sysCtrl_reg[`ADCAC_SYS_RUN] & ~loadBusy;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      seqState <= S_IDLE;
      seqCnt <= 16'h0000;
      convChan <= 3'd7;
      convStart <= 1'b0;
    end else begin
      convStart <= 1'b0;
      case (seqState)
        S_IDLE: begin
          // disabled channels cost one cycle each while scanning
          if (seqRun && seqMask_reg != 8'h00) begin
            convChan <= nextChan;
            if (seqMask_reg[nextChan]) begin
              seqCnt <=
                chCtl_reg[nextChan][`ADCAC_CTL_DLY_HI:`ADCAC_CTL_DLY_LO];
              seqState <= S_DELAY;
            end
          end
        end
        S_DELAY: begin
          if (seqCnt == 16'h0000) begin
            convStart <= 1'b1;
            seqCnt <= convCycles;
            seqState <= S_CONV;
          end else begin
            seqCnt <= seqCnt - 16'h0001;
          end
        end
        S_CONV: begin
          if (seqCnt == 16'h0000)
            seqState <= S_IDLE;
          else
            seqCnt <= seqCnt - 16'h0001;
        end
        default: seqState <= S_IDLE;
      endcase
    end
  end
endmodule

/* File: adcac_monitor.sv */
// concurrent checks on the adcac_top ports
`timescale 1ns/1ns
`include "adcac_map.vh"
module adcac_monitor (
  input wire core_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire rawValid,
  input wire [2:0] rawChan,
  input wire convStart,
  input wire resValid,
  input wire [2:0] resChan,
  input wire [31:0] resWord,
  input wire nvmRdReq,
  input wire [4:0] nvmAddr,
  input wire nvmAck,
  input wire loadBusy,
  input wire [9:0] gpioOe_n
);
  wire [9:0] dirData = pwdata[9:0];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence s_nvm_take;
    nvmRdReq && nvmAck;
  endsequence
  sequence s_dir_write;
    psel && penable && pready && pwrite && paddr == `ADCAC_GPIO_DIR;
  endsequence
  a_overload_max: assert property (resValid && resWord[31] |->
    resWord[23:0] == 24'hFF_FFFF) else $error("overload below max code");
  a_result_timing: assert property (rawValid |-> ##2 resValid &&
    resChan == $past(rawChan, 2)) else $error("result late or wrong chan");
  a_no_stray: assert property (resValid |->
    $past(rawValid, 2)) else $error("result without raw code");
  a_nvm_step: assert property (s_nvm_take ##0 nvmAddr != 5'h1F |=>
    nvmAddr == $past(nvmAddr) + 5'h01) else $error("nvm index skipped");
  a_nvm_finish: assert property (s_nvm_take ##0 nvmAddr == 5'h1F |=>
    !nvmRdReq && !loadBusy) else $error("load did not end");
  a_nvm_wait: assert property (nvmRdReq && !nvmAck |=>
    nvmRdReq && $stable(nvmAddr)) else $error("nvm request dropped");
  a_dir_follow: assert property (s_dir_write |=>
    gpioOe_n == ~$past(dirData)) else $error("pin direction wrong");
  a_conv_pulse: assert property (convStart |=>
    !convStart) else $error("start pulse too long");
  a_apb_answer: assert property (psel && !penable |=>
    pready) else $error("no ready after setup");
endmodule

bind adcac_top adcac_monitor u_mon (.core_clk, .rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .rawValid, .rawChan, .convStart,
  .resValid, .resChan, .resWord, .nvmRdReq, .nvmAddr, .nvmAck, .loadBusy,
  .gpioOe_n);

/* File: adcac_nvm_model.sv */
// factory coefficient store answering the reset-time load
`timescale 1ns/1ns
module adcac_nvm_model (
  input wire core_clk,
  input wire rst,
  input wire nvmRdReq,
  input wire [4:0] nvmAddr,
  output wire nvmAck,
  output wire nvmHasData,
  output wire [23:0] nvmData
);
  reg phase_reg;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
    end
  end
  // gains come slowly, offsets back to back
  assign nvmAck = nvmRdReq && (nvmAddr[4] || phase_reg);
  // only pairs 0-7 hold factory values; junk when not acking
  assign nvmHasData = nvmAck ? !nvmAddr[3] : phase_reg;
  assign nvmData = nvmAck ? 24'h10_0000 + {19'h0, nvmAddr} :
    {24{phase_reg}} ^ 24'hA5_A5A5;
endmodule

/* File: tb_adc_alarm_and_calibration.sv */
// register-level bench for the alarm and calibration back end
`timescale 1ns/1ns
`include "adcac_map.vh"
module tb_adc_alarm_and_calibration;
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg psel, penable, pwrite, rawValid, rdErr;
  reg [11:0] paddr, i;
  reg [31:0] pwdata, rdData;
  reg [2:0] rawChan;
  reg [23:0] rawCode;
  reg [9:0] gpioIn;
  reg overTempPin, overVoltPin, crcErrPin;
  wire [31:0] prdata, resWord;
  wire pready, pslverr, convStart, resValid, nvmRdReq, nvmAck;
  wire nvmHasData, loadBusy;
  wire [2:0] convChan, resChan;
  wire [4:0] nvmAddr;
  wire [23:0] nvmData;
  wire [9:0] gpioOut, gpioOe_n;
  integer errorCnt = 0, checked = 0, cycles = 0, n1, n2;

  adcac_top DUT (.core_clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rawValid, .rawChan, .rawCode,
    .convStart, .convChan, .resValid, .resChan, .resWord, .nvmRdReq,
    .nvmAddr, .nvmAck, .nvmHasData, .nvmData, .loadBusy,
    .overTempPin, .overVoltPin, .crcErrPin,
    .gpioIn, .gpioOut, .gpioOe_n);
  adcac_nvm_model partner (.core_clk, .rst, .nvmRdReq, .nvmAddr, .nvmAck,
    .nvmHasData, .nvmData);

  initial begin
    forever #5 core_clk = ~core_clk;
  end
  // the whole run needs a few hundred cycles
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      errorCnt = errorCnt + 1;
      conclude;
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task conclude;
    $display("checked %0d errors %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task chk(input string name, input logic [31:0] seen, input logic [31:0] e);
    checked = checked + 1;
    if (seen !== e) begin
      errorCnt = errorCnt + 1;
      $display("wrong value %s expected %h seen %h", name, e, seen);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("prdata", rdData, e);
  endtask
  task res(input logic [2:0] c, input logic [23:0] code,
           input logic [23:0] e, input logic [7:0] st);
    @(posedge core_clk);
    rawValid <= 1'b1;
    rawChan <= c;
    rawCode <= code;
    @(posedge core_clk);
    rawValid <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("resValid", {31'h0, resValid}, 32'h1);
    chk("resChan", {29'h0, resChan}, {29'h0, c});
    chk("resWord", {8'h0, resWord[23:0]}, {8'h0, e});
    chk("status", {24'h0, resWord[31:24]}, {24'h0, st});
  endtask
  task gap(output integer n);
    n = 0;
    do @(posedge core_clk); while (convStart !== 1'b1);
    chk("convChan", {29'h0, convChan}, 32'h2);
    do begin
      @(posedge core_clk);
      n = n + 1;
    end while (convStart !== 1'b1);
  endtask
  // ----------------------------------------
  // sequence of tests
  // ----------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    rawValid = 1'b0;
    rawChan = 3'h0;
    rawCode = 24'h0;
    gpioIn = 10'h000;
    overTempPin = 1'b0;
    overVoltPin = 1'b1;
    crcErrPin = 1'b1;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    do @(posedge core_clk); while (loadBusy !== 1'b0);
    rd(`ADCAC_STATUS, 32'h0000_001C);
    for (i = 0; i < 16; i++) begin
      rd(12'h200 + (i << 2),
        (i < 8) ? 32'h0010_0000 + i : 32'h0040_0000);
      rd(12'h240 + (i << 2), (i < 8) ? 32'h0010_0010 + i : 32'h0);
    end
    wr(12'h224, 32'h0080_0000);
    wr(12'h264, 32'h0000_0010);
    rd(12'h224, 32'h0080_0000);
    wr(`ADCAC_SYS_CTRL, 32'h2);
    wr(12'h100, 32'h0000_9010);
    wr(12'h10C, 32'h1);
    wr(12'h108, 32'h0000_0300);
    wr(12'h104, 32'h00FF_FFFF);
    wr(12'h110, 32'h0000_9010);
    wr(12'h114, 32'h003F_FFFF);
    wr(12'h118, 32'h00BF_FFFF);
    res(3'd0, 24'h00_0100, 24'h00_0220, 8'h13);
    res(3'd0, 24'h7F_FFF8, 24'hFF_FFFF, 8'h87);
    overTempPin <= 1'b1;
    res(3'd1, 24'h3F_FFF0, 24'h7F_FFFF, 8'h2F);
    rd(`ADCAC_ALARM, 32'h0001_0102);
    rd(`ADCAC_ALARM, 32'h0);
    wr(`ADCAC_SYS_CTRL, 32'h3);
    res(3'd0, 24'h7F_FFF8, 24'hFF_FFFF, 8'h8B);
    rd(`ADCAC_ALARM, 32'h0001_0000);
    rd(`ADCAC_ALARM, 32'h0001_0000);
    wr(`ADCAC_ALARM, 32'h0001_0000);
    rd(`ADCAC_ALARM, 32'h0);
    rd(12'h7F0, 32'h0);
    chk("pslverr", {31'h0, rdErr}, 32'h1);
    rd(12'h002, 32'h0);
    chk("pslverr", {31'h0, rdErr}, 32'h1);
    wr(`ADCAC_GPIO_DIR, 32'h0000_03F0);
    wr(`ADCAC_GPIO_OUT, 32'h0000_02A0);
    gpioIn <= 10'h155;
    #1;
    chk("gpioOe_n", {22'h0, gpioOe_n}, {22'h0, ~10'h3F0});
    chk("gpioOut", {22'h0, gpioOut}, 32'h0000_02A0);
    wr(`ADCAC_GPIO_IN, 32'h0000_03FF);
    rd(`ADCAC_GPIO_IN, 32'h0000_0155);
    wr(12'h120, 32'h0000_0001);
    wr(12'h12C, 32'h0003_0000);
    wr(`ADCAC_SEQ_MASK, 32'h4);
    wr(`ADCAC_SYS_CTRL, 32'h7);
    gap(n1);
    chk("slotCycles", n1, 32'd29);
    wr(12'h12C, 32'h000D_0000);
    gap(n2);
    gap(n2);
    chk("delayStep", n2 - n1, 32'd10);
    conclude;
  end
endmodule
